// ---- verilog/return_and_option_instr_exec.sv ----
// Purpose: executes option-load, no-op and the two return instructions
// Assumes: instruction word comes from program memory on core_clk
// Notes:   returns stall fetch for one extra cycle while the pipe refills
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - The option-load word copies the working register into the option register and touches no flags.
// - A move-to-file aimed at the option register address also writes it, and its value is always readable.
// - Return-from-interrupt pops the return stack into the program counter and takes two cycles.
// - Return-from-interrupt sets the global interrupt enable bit, bit 7 of the interrupt control register.
// - Return-with-literal loads its eight-bit literal into the working register, ignoring bits 9 and 8.
// - Return-with-literal pops the return stack into the program counter and takes two cycles.
module return_and_option_instr_exec
#(
  parameter int STACK_DEPTH = instr_exec_pkg::STACK_DEPTH
)
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [13:0] instrWord,
  input  wire logic        instrValid,
  input  wire logic        pushEn,
  input  wire logic [12:0] pushAddr,
  input  wire logic        wLoadEn,
  input  wire logic [7:0]  wLoadData,
  input  wire logic        intEnClr,
  output logic      [12:0] pc,
  output logic      [7:0]  wreg,
  output logic      [7:0]  optionReg,
  output logic      [7:0]  intCtrl,
  output logic             fetchStall,
  output logic             stackEmpty
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  typedef enum logic { ST_EXEC, ST_REFILL } state_e;

  // ==========================================================
  // decode
  instr_exec_pkg::decoded_s dec;

  instr_decode u_decode
  (
    .instrWord (instrWord),
    .decoded   (dec)
  );

  state_e            state_r;
  state_e            state_nxt;
  logic [12:0]       pc_r;
  logic [12:0]       pc_nxt;
  logic [7:0]        wreg_r;
  logic [7:0]        wreg_nxt;
  logic [7:0]        option_r;
  logic [7:0]        option_nxt;
  logic [7:0]        intCtrl_r;
  logic [7:0]        intCtrl_nxt;
  logic [SP_W-1:0]   sp_r;
  logic [SP_W-1:0]   sp_nxt;
  logic [12:0]       stack_r [STACK_DEPTH];

  // ==========================================================
  // class match, gated by the execute slot; operands passed in so
  // the continuous assignments below see every change of them
  function automatic logic opIs
  (
    input logic                slot,
    input instr_exec_pkg::op_e have,
    input instr_exec_pkg::op_e want
  );
    return slot && (have == want);
  endfunction

  wire       exec     = instrValid && (state_r == ST_EXEC);
  wire       isOpt    = opIs(exec, dec.op, instr_exec_pkg::OP_OPT_LOAD);
  wire       isRetInt = opIs(exec, dec.op, instr_exec_pkg::OP_RET_INT);
  wire       isRetLit = opIs(exec, dec.op, instr_exec_pkg::OP_RET_LIT);
  wire       isMovOpt = opIs(exec, dec.op, instr_exec_pkg::OP_MOV_FILE)
                        && (dec.fileAddr == instr_exec_pkg::OPTION_FILE);
  wire       isReturn = isRetInt || isRetLit;
  // circular stack: top is the entry just below the pointer
  wire [SP_W-1:0] topIdx  = sp_r - SP_W'(1);
  wire [12:0]     topAddr = stack_r[topIdx];

  // ==========================================================
  // next state
  assign state_nxt = isReturn ? ST_REFILL : ST_EXEC;

  // a return wins over a push in the same cycle; both cannot be legal
  assign sp_nxt = isReturn ? topIdx :
                  pushEn   ? sp_r + SP_W'(1) :
                             sp_r;

  // any executed word that is not a return only steps the counter; with no word executed it holds
  assign pc_nxt = isReturn ? topAddr :
                  exec     ? pc_r + 13'h0001 :
                             pc_r;

  assign wreg_nxt = isRetLit ? dec.literal :
                    wLoadEn  ? wLoadData :
                               wreg_r;

  assign option_nxt = (isOpt || isMovOpt) ? wreg_r :
                                            option_r;

  // set from the return wins over a clear arriving in the same cycle
  always_comb
  begin
    intCtrl_nxt = intCtrl_r;
    if (intEnClr)
    begin
      intCtrl_nxt[instr_exec_pkg::INT_EN_BIT] = 1'b0;
    end
    if (isRetInt)
    begin
      intCtrl_nxt[instr_exec_pkg::INT_EN_BIT] = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r   <= ST_EXEC;
      pc_r      <= instr_exec_pkg::PC_RST;
      sp_r      <= '0;
    end
    else
    begin
      state_r   <= state_nxt;
      pc_r      <= pc_nxt;
      sp_r      <= sp_nxt;
    end
  end

  // data registers seen by the rest of the core
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wreg_r    <= instr_exec_pkg::WREG_RST;
      option_r  <= instr_exec_pkg::OPTION_RST;
      intCtrl_r <= {instr_exec_pkg::INT_EN_RST, 7'h00};
    end
    else
    begin
      wreg_r    <= wreg_nxt;
      option_r  <= option_nxt;
      intCtrl_r <= intCtrl_nxt;
    end
  end

  // ==========================================================
  // return stack
  // stack storage needs no reset; only pointer state matters
  always_ff @(posedge core_clk)
  begin
    if (pushEn && !isReturn)
    begin
      stack_r[sp_r] <= pushAddr;
    end
  end

  // depth counter for the empty flag; the pointer wraps, this saturates
  logic [SP_W:0] depth_r;
  logic [SP_W:0] depth_nxt;
  wire           depthZero = (depth_r == '0);
  // a full stack overwritten by further pushes must still read full
  wire           depthFull = (depth_r == (SP_W+1)'(STACK_DEPTH));
  assign depth_nxt = isReturn ? (depthZero ? depth_r
                                           : depth_r - (SP_W+1)'(1)) :
                     (pushEn && !depthFull) ? depth_r + (SP_W+1)'(1) :
                                              depth_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      depth_r <= '0;
    end
    else
    begin
      depth_r <= depth_nxt;
    end
  end

  // ==========================================================
  // outputs, all registered
  // taken from the next-state values so the stall and the empty flag
  // appear right after the edge that caused them
  logic fetchStall_r;
  logic stackEmpty_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fetchStall_r <= 1'b0;
      stackEmpty_r <= 1'b1;
    end
    else
    begin
      fetchStall_r <= (state_nxt == ST_REFILL);
      stackEmpty_r <= (depth_nxt == '0);
    end
  end

  assign pc         = pc_r;
  assign wreg       = wreg_r;
  assign optionReg  = option_r;
  assign intCtrl    = intCtrl_r;
  assign fetchStall = fetchStall_r;
  assign stackEmpty = stackEmpty_r;

endmodule // return_and_option_instr_exec

`default_nettype wire

// ---- verilog/instr_exec_pkg.sv ----
// Purpose: shared constants and types for the return/option executor
// Assumes: 14-bit instruction words, 13-bit program counter
// Notes:   encodings are exact 14-bit patterns or masked compares
`default_nettype none

package instr_exec_pkg;

  // ==========================================================
  // widths and reset values
  localparam int          INSTR_W      = 14;
  localparam int          PC_W         = 13;
  localparam int          DATA_W       = 8;
  localparam int          STACK_DEPTH  = 8;
  localparam logic [12:0] PC_RST       = 13'h0000;
  localparam logic [7:0]  WREG_RST     = 8'h00;
  localparam logic [7:0]  OPTION_RST   = 8'hFF;
  localparam logic        INT_EN_RST   = 1'b0;
  localparam int          INT_EN_BIT   = 7;

  // ==========================================================
  // encodings
  localparam logic [13:0] OPT_LOAD_CODE = 14'h0062;
  localparam logic [13:0] RET_INT_CODE  = 14'h0009;
  localparam logic [13:0] NOP_MASK      = 14'h3F9F;
  localparam logic [13:0] NOP_CODE      = 14'h0000;
  localparam logic [13:0] RET_LIT_MASK  = 14'h3C00;
  localparam logic [13:0] RET_LIT_CODE  = 14'h3400;
  localparam logic [13:0] MOV_FILE_MASK = 14'h3F80;
  localparam logic [13:0] MOV_FILE_CODE = 14'h0080;
  localparam logic [6:0]  OPTION_FILE   = 7'h01;

  // ==========================================================
  // cycle counts
  localparam int RETURN_CYCLES = 2;

  typedef enum logic [2:0] {
    OP_OTHER,
    OP_NOP,
    OP_OPT_LOAD,
    OP_RET_INT,
    OP_RET_LIT,
    OP_MOV_FILE
  } op_e;

  typedef struct packed {
    op_e        op;
    logic [7:0] literal;
    logic [6:0] fileAddr;
  } decoded_s;

endpackage

`default_nettype wire

// ---- verilog/instr_decode.sv ----
// Purpose: classify one instruction word for the executor
// Assumes: word is stable in the cycle it is decoded
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none

module instr_decode
(
  input  wire logic [13:0]                 instrWord,
  output var instr_exec_pkg::decoded_s     decoded
);

  // ==========================================================
  // pattern matches
  wire isOptLoad = (instrWord == instr_exec_pkg::OPT_LOAD_CODE);
  wire isRetInt  = (instrWord == instr_exec_pkg::RET_INT_CODE);
  wire isNop     = ((instrWord & instr_exec_pkg::NOP_MASK)
                    == instr_exec_pkg::NOP_CODE);
  // bits 9:8 ignored on purpose
  wire isRetLit  = ((instrWord & instr_exec_pkg::RET_LIT_MASK)
                    == instr_exec_pkg::RET_LIT_CODE);
  wire isMovFile = ((instrWord & instr_exec_pkg::MOV_FILE_MASK)
                    == instr_exec_pkg::MOV_FILE_CODE);

  assign decoded.op = isOptLoad ? instr_exec_pkg::OP_OPT_LOAD :
                      isRetInt  ? instr_exec_pkg::OP_RET_INT  :
                      isNop     ? instr_exec_pkg::OP_NOP      :
                      isRetLit  ? instr_exec_pkg::OP_RET_LIT  :
                      isMovFile ? instr_exec_pkg::OP_MOV_FILE :
                                  instr_exec_pkg::OP_OTHER;
  assign decoded.literal  = instrWord[7:0];
  assign decoded.fileAddr = instrWord[6:0];

endmodule // instr_decode

`default_nettype wire

// ---- dv/return_exec_assertions.sv ----
// Purpose: port checker for the return/option executor
// Assumes: one clock, async active-low reset
// Notes:   take marks a word accepted outside a return stall
`timescale 1ns/10ps
`default_nettype none

module return_exec_assertions
#(
  parameter int STACK_DEPTH = 8
)
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [13:0] instrWord,
  input wire logic        instrValid,
  input wire logic        pushEn,
  input wire logic [12:0] pushAddr,
  input wire logic        wLoadEn,
  input wire logic [7:0]  wLoadData,
  input wire logic        intEnClr,
  input wire logic [12:0] pc,
  input wire logic [7:0]  wreg,
  input wire logic [7:0]  optionReg,
  input wire logic [7:0]  intCtrl,
  input wire logic        fetchStall,
  input wire logic        stackEmpty
);
  // ==========================================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic take = instrValid && !fetchStall;
  wire logic lit = take && instrWord[13:10] == 4'hD;
  wire logic rfi = take && instrWord == 14'h0009;

  a_opt_load_copy: assert property (
    take && instrWord == 14'h0062 |=>
      optionReg == $past(wreg) && pc == $past(pc) + 13'h1)
    else $error("option load did not copy wreg");
  a_file_opt_write: assert property (
    take && instrWord == 14'h0081 |=> optionReg == $past(wreg))
    else $error("file write missed option register");
  a_rfi_two_cyc: assert property (
    rfi |=> fetchStall ##1 !fetchStall && $stable(pc))
    else $error("interrupt return not two cycles");
  a_rfi_enable_set: assert property (
    rfi |=> intCtrl == 8'h80)
    else $error("interrupt return left enable clear");
  a_lit_to_w: assert property (
    lit |=> wreg == $past(instrWord[7:0]))
    else $error("literal not loaded into wreg");
  a_lit_two_cyc: assert property (
    lit |=> fetchStall ##1 !fetchStall)
    else $error("literal return not two cycles");
  a_nop_quiet: assert property (
    take && (instrWord & 14'h3F9F) == 14'h0000 && !wLoadEn && !intEnClr
      && !pushEn |=> pc == $past(pc) + 13'h1 && $stable(wreg)
      && $stable(optionReg) && $stable(intCtrl) && !fetchStall)
    else $error("no-op changed state");
  c_rfi: cover property (rfi);
  c_lit: cover property (lit);
  c_opt: cover property (take && instrWord == 14'h0062);
endmodule // return_exec_assertions

`default_nettype wire

// ---- dv/prog_mem_model.sv ----
// Purpose: program memory feeding queued words to the executor
// Assumes: bench appends words to q
// Notes:   idle bus toggles so stale words never look valid
`timescale 1ns/10ps
`default_nettype none

module prog_mem_model
(
  input  wire logic        core_clk,
  input  wire logic        fetchStall,
  output var  logic [13:0] instrWord,
  output var  logic        instrValid
);
  logic [13:0] q[$];
  initial
  begin
    instrWord = 14'h0000;
    instrValid = 1'b0;
  end
  // ==========================================================
  // fetch: nothing offered while the core refills its pipe
  always @(negedge core_clk)
    if (q.size() > 0 && fetchStall === 1'b0)
    begin
      instrWord = q.pop_front();
      instrValid = 1'b1;
    end
    else
    begin
      instrWord = ~instrWord;
      instrValid = 1'b0;
    end
endmodule // prog_mem_model

`default_nettype wire

// ---- dv/return_and_option_instr_exec_tb.sv ----
// Purpose: random self-checking bench with a reference model
// Assumes: side inputs change on falling edges
// Notes:   returns are swapped for no-ops while the stack is empty
`timescale 1ns/10ps
`default_nettype none

module return_and_option_instr_exec_tb;
  logic core_clk = 1'b0, nrst = 1'b0, pushEn = 1'b0, wLoadEn = 1'b0;
  logic intEnClr = 1'b0, fetchStall, stackEmpty, instrValid, ex, rfi, rl;
  logic [13:0] instrWord;
  logic [12:0] pushAddr = 13'h0000, pc, mPc;
  logic [7:0] wLoadData = 8'h00, wreg, optionReg, intCtrl, mW, mOpt, mInt;
  logic mStall;
  int stk[$], mismatches = 0, check_count = 0;

  prog_mem_model mem (.core_clk(core_clk), .fetchStall(fetchStall),
    .instrWord(instrWord), .instrValid(instrValid));
  return_and_option_instr_exec DUT (.core_clk(core_clk), .nrst(nrst),
    .instrWord(instrWord), .instrValid(instrValid), .pushEn(pushEn),
    .pushAddr(pushAddr), .wLoadEn(wLoadEn), .wLoadData(wLoadData),
    .intEnClr(intEnClr), .pc(pc), .wreg(wreg), .optionReg(optionReg),
    .intCtrl(intCtrl), .fetchStall(fetchStall), .stackEmpty(stackEmpty));

  initial
    forever #5 core_clk = ~core_clk;

  // ==========================================================
  // reference model; literal beats wLoad, enable set beats clear
  always @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      mPc = 13'h0000;
      mW = 8'h00;
      mOpt = 8'hFF;
      mInt = 8'h00;
      mStall = 1'b0;
      stk = {};
    end
    else
    begin
      ex = instrValid && !mStall;
      rfi = ex && instrWord == 14'h0009;
      rl = ex && instrWord[13:10] == 4'hD;
      if (ex && (instrWord == 14'h0062 || instrWord == 14'h0081))
        mOpt = mW;
      if (wLoadEn)
        mW = wLoadData;
      if (rl)
        mW = instrWord[7:0];
      if (intEnClr)
        mInt = 8'h00;
      if (rfi)
        mInt = 8'h80;
      mStall = rfi || rl;
      if (mStall)
        mPc = 13'(stk.pop_back());
      else if (ex)
        mPc = mPc + 13'h1;
      if (pushEn && !mStall)
        stk.push_back(int'(pushAddr));
      if (stk.size() > instr_exec_pkg::STACK_DEPTH)
        void'(stk.pop_front());
    end

  task automatic cmp(string n, logic [12:0] e, logic [12:0] s);
    check_count++;
    if (e !== s)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // ==========================================================
  // compare settled outputs, then drive random side inputs
  always @(negedge core_clk)
  begin
    if (nrst)
    begin
      cmp("pc", mPc, pc);
      cmp("wreg", 13'(mW), 13'(wreg));
      cmp("optionReg", 13'(mOpt), 13'(optionReg));
      cmp("intCtrl", 13'(mInt), 13'(intCtrl));
      cmp("fetchStall", 13'(mStall), 13'(fetchStall));
      cmp("stackEmpty", 13'(stk.size() == 0), 13'(stackEmpty));
    end
    pushEn = $urandom % 4 == 0;
    pushAddr = 13'($urandom);
    wLoadEn = $urandom % 3 == 0;
    wLoadData = 8'($urandom);
    intEnClr = $urandom % 5 == 0;
  end

  function automatic logic [13:0] pick(int k);
    case (k)
      0: return {7'h00, 2'($urandom), 5'h00};
      1: return 14'h0062;
      2: return 14'h0081;
      3: return 14'h0009;
      4: return {4'hD, 10'($urandom)};
      default: return 14'($urandom);
    endcase
  endfunction

  task automatic step(logic [13:0] w);
    for (int n = 0; n < 4 && (n == 0 || mem.q.size() > 0); n++)
    begin
      @(posedge core_clk);
      #1;
    end
    if ((w == 14'h0009 || w[13:10] == 4'hD) && stk.size() == 0)
      w = 14'h0000;
    mem.q.push_back(w);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'h02DE86B7));
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    for (int i = 0; i < 600; i++)
      step(pick(i % 6));
    repeat (4) @(posedge core_clk);
    complete_run();
  end

  initial
  begin
    #50000;
    mismatches++;
    complete_run();
  end
endmodule // return_and_option_instr_exec_tb

bind return_and_option_instr_exec return_exec_assertions
  #(.STACK_DEPTH(STACK_DEPTH)) chk (.core_clk(core_clk), .nrst(nrst),
  .instrWord(instrWord), .instrValid(instrValid), .pushEn(pushEn),
  .pushAddr(pushAddr), .wLoadEn(wLoadEn), .wLoadData(wLoadData),
  .intEnClr(intEnClr), .pc(pc), .wreg(wreg), .optionReg(optionReg),
  .intCtrl(intCtrl), .fetchStall(fetchStall), .stackEmpty(stackEmpty));

`default_nettype wire
